// ===== pkg/svt_pkg.sv
// How it works
// - three-bit observe select routes one calibration signal to the observation output
// - four-bit tuning voltage target, reset 0111, used only in test mode
// - eight-bit read-write converter offset correction, resets to 0x55
// - two-bit charge pump test mode: 00 tristate, 11 normal, reset 11
// - sixteen-bit oscillator counter readable at 0x6E low and 0x6F high
// - three-bit buffer trim in bits 7:5, resets to 7
package svt_pkg;
  // register offsets
  localparam logic [6:0] OFS_MUX_TUNE = 7'h39;
  localparam logic [6:0] OFS_ADC_OFS = 7'h3a;
  localparam logic [6:0] OFS_SD_RST = 7'h3d;
  localparam logic [6:0] OFS_CP_TEST = 7'h3e;
  localparam logic [6:0] OFS_CLK1_LO = 7'h3f;
  localparam logic [6:0] OFS_CLK1_HI = 7'h40;
  localparam logic [6:0] OFS_CLK2_LO = 7'h41;
  localparam logic [6:0] OFS_CLK2_HI = 7'h42;
  localparam logic [6:0] OFS_MUX_TRIM = 7'h47;
  localparam logic [6:0] OFS_BUF_TRIM = 7'h52;
  localparam logic [6:0] OFS_CNT_LO = 7'h6e;
  localparam logic [6:0] OFS_CNT_HI = 7'h6f;
  localparam logic [6:0] OFS_DBL_BIAS = 7'h70;
  // writable bit masks
  localparam logic [7:0] WMSK_MUX_TUNE = 8'h7f;
  localparam logic [7:0] WMSK_SD_RST = 8'h40;
  localparam logic [7:0] WMSK_CP_TEST = 8'h0c;
  localparam logic [7:0] WMSK_CLK1_HI = 8'h7f;
  localparam logic [7:0] WMSK_MUX_TRIM = 8'he0;
  localparam logic [7:0] WMSK_BUF_TRIM = 8'hfc;
  localparam logic [7:0] WMSK_DBL_BIAS = 8'he3;
  localparam logic [7:0] WMSK_FULL = 8'hff;
  // reset values
  localparam logic [7:0] RST_MUX_TUNE = 8'h07;
  localparam logic [7:0] RST_ADC_OFS = 8'h55;
  localparam logic [7:0] RST_SD_RST = 8'h00;
  localparam logic [7:0] RST_CP_TEST = 8'h0c;
  localparam logic [7:0] RST_CLK1_LO = 8'h80;
  localparam logic [7:0] RST_CLK1_HI = 8'h50;
  localparam logic [7:0] RST_CLK2_LO = 8'h28;
  localparam logic [7:0] RST_CLK2_HI = 8'h00;
  localparam logic [7:0] RST_MUX_TRIM = 8'hc0;
  localparam logic [7:0] RST_BUF_TRIM = 8'hf4;
  localparam logic [7:0] RST_DBL_BIAS = 8'h03;
  // field positions
  localparam int OBS_SEL_LSB = 4;
  localparam int TUNE_LSB = 0;
  localparam int CP_MODE_LSB = 2;
  localparam int BUF_TRIM_LSB = 5;
  // observe select codes
  localparam logic [2:0] OBS_BUSY = 3'h0;
  localparam logic [2:0] OBS_NBAND = 3'h1;
  localparam logic [2:0] OBS_RBAND = 3'h2;
  localparam logic [2:0] OBS_RSVD = 3'h3;
  localparam logic [2:0] OBS_TCLK = 3'h4;
  localparam logic [2:0] OBS_BIAS_MIN = 3'h5;
  localparam logic [2:0] OBS_ADC_BUSY = 3'h6;
  localparam logic [2:0] OBS_LOW = 3'h7;
  // charge pump modes
  localparam logic [1:0] CP_TRISTATE = 2'h0;
  localparam logic [1:0] CP_NORMAL = 2'h3;
  // number of writable registers
  localparam int NREG = 11;
  // stage count of the three-stage pin synchroniser; svt_sync hardcodes its three stages and does not read it
  localparam int SYNC_STAGES = 3;
endpackage

// ===== design/svt_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module svt_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // asynchronous level
  input wire logic async_in,
  // filtered level
  output logic level_out
);
  import svt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } svt_sync_t;

  svt_sync_t st;
  svt_sync_t next_st;

  // shift and accept only on agreement, so a late metastable settle counts once
  always_comb
  begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.lvl = st.s3;
    end
    if (sys_rst_in)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  assign level_out = st.lvl;
endmodule // svt_sync

// ===== design/svt_obs_mux.sv
`timescale 1ns/1ps
// picks one calibration signal for the observation point
module svt_obs_mux (
  // select
  input wire logic [2:0] sel_in,
  // candidate signals
  input wire logic busy_in,
  input wire logic nband_in,
  input wire logic rband_in,
  input wire logic tclk_in,
  input wire logic bias_min_in,
  input wire logic adc_busy_in,
  // routed signal
  output logic obs_out
);
  import svt_pkg::*;

  // reserved code drives low, as does the explicit low code
  always_comb
  begin
    unique case (sel_in)
      OBS_BUSY: obs_out = busy_in;
      OBS_NBAND: obs_out = nband_in;
      OBS_RBAND: obs_out = rband_in;
      OBS_RSVD: obs_out = 1'b0;
      OBS_TCLK: obs_out = tclk_in;
      OBS_BIAS_MIN: obs_out = bias_min_in;
      OBS_ADC_BUSY: obs_out = adc_busy_in;
      OBS_LOW: obs_out = 1'b0;
    endcase
  end
endmodule // svt_obs_mux

// ===== design/svt_regbank.sv
`timescale 1ns/1ps
// register bank for calibration test, trim and counter readback
module svt_regbank (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register access from the serial port decoder
  input wire logic [6:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // calibration signals to observe (same clock domain)
  input wire logic cal_busy_in,
  input wire logic cal_nband_in,
  input wire logic cal_rband_in,
  input wire logic cal_bias_min_in,
  input wire logic cal_adc_busy_in,
  // timeout clock from the analog side, asynchronous
  input wire logic cal_tclk_in,
  // counter value from the calibration engine
  input wire logic [15:0] oscillator_counter_value_in,
  input wire logic counter_valid_in,
  // observation point and analog controls
  output logic calibration_observe_out,
  output logic [2:0] calibration_observe_select_out,
  output logic [3:0] tuning_voltage_target_out,
  output logic [7:0] converter_offset_out,
  output logic sigma_delta_reset_out,
  output logic [1:0] charge_pump_test_mode_out,
  output logic charge_pump_tristate_out,
  output logic [11:0] first_clock_divider_out,
  output logic [2:0] buffer_bias_trim_out,
  output logic [11:0] second_clock_divider_1_out,
  output logic [3:0] second_clock_divider_2_out,
  output logic [2:0] oscillator_mux_trim_out,
  output logic [2:0] oscillator_buffer_trim_out,
  output logic [2:0] buffer_current_trim_out,
  output logic [2:0] doubler_filter_select_out,
  output logic [1:0] doubler_bias_select_out
);
  import svt_pkg::*;

  typedef struct packed {
    logic [7:0] mux_tune;
    logic [7:0] adc_ofs;
    logic [7:0] sd_rst;
    logic [7:0] cp_test;
    logic [7:0] clk1_lo;
    logic [7:0] clk1_hi;
    logic [7:0] clk2_lo;
    logic [7:0] clk2_hi;
    logic [7:0] mux_trim;
    logic [7:0] buf_trim;
    logic [7:0] dbl_bias;
    logic [15:0] cnt;
    logic [7:0] rdata;
    logic hit;
  } svt_bank_t;

  svt_bank_t st;
  svt_bank_t next_st;
  logic tclk_sync;
  logic obs_raw;
  logic [7:0] rd_mux;
  logic rd_map;

  // timeout clock is asynchronous, so it is filtered before routing
  svt_sync u_tclk_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(cal_tclk_in),
    .level_out(tclk_sync)
  );

  svt_obs_mux u_obs_mux (
    .sel_in(st.mux_tune[OBS_SEL_LSB +: 3]),
    .busy_in(cal_busy_in),
    .nband_in(cal_nband_in),
    .rband_in(cal_rband_in),
    .tclk_in(tclk_sync),
    .bias_min_in(cal_bias_min_in),
    .adc_busy_in(cal_adc_busy_in),
    .obs_out(obs_raw)
  );

  // masked write keeps reserved bits at zero
  function automatic logic [7:0] mwr(input logic [7:0] cur, input logic [7:0] wd,
                                     input logic [7:0] msk);
    mwr = (cur & ~msk) | (wd & msk);
  endfunction

  // read decode; only stored bits can be nonzero, so reserved bits read zero
  always_comb
  begin
    rd_map = 1'b1;
    unique case (reg_addr_in)
      OFS_MUX_TUNE: rd_mux = st.mux_tune;
      OFS_ADC_OFS: rd_mux = st.adc_ofs;
      OFS_SD_RST: rd_mux = st.sd_rst;
      OFS_CP_TEST: rd_mux = st.cp_test;
      OFS_CLK1_LO: rd_mux = st.clk1_lo;
      OFS_CLK1_HI: rd_mux = st.clk1_hi;
      OFS_CLK2_LO: rd_mux = st.clk2_lo;
      OFS_CLK2_HI: rd_mux = st.clk2_hi;
      OFS_MUX_TRIM: rd_mux = st.mux_trim;
      OFS_BUF_TRIM: rd_mux = st.buf_trim;
      OFS_CNT_LO: rd_mux = st.cnt[7:0];
      OFS_CNT_HI: rd_mux = st.cnt[15:8];
      OFS_DBL_BIAS: rd_mux = st.dbl_bias;
      default:
      begin
        rd_mux = 8'h00;
        rd_map = 1'b0;
      end
    endcase
  end

  // write path and readback capture
  always_comb
  begin
    next_st = st;
    if (counter_valid_in)
    begin
      next_st.cnt = oscillator_counter_value_in;
    end
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        OFS_MUX_TUNE: next_st.mux_tune = mwr(st.mux_tune, reg_wdata_in, WMSK_MUX_TUNE);
        OFS_ADC_OFS: next_st.adc_ofs = mwr(st.adc_ofs, reg_wdata_in, WMSK_FULL);
        OFS_SD_RST: next_st.sd_rst = mwr(st.sd_rst, reg_wdata_in, WMSK_SD_RST);
        OFS_CP_TEST: next_st.cp_test = mwr(st.cp_test, reg_wdata_in, WMSK_CP_TEST);
        OFS_CLK1_LO: next_st.clk1_lo = mwr(st.clk1_lo, reg_wdata_in, WMSK_FULL);
        OFS_CLK1_HI: next_st.clk1_hi = mwr(st.clk1_hi, reg_wdata_in, WMSK_CLK1_HI);
        OFS_CLK2_LO: next_st.clk2_lo = mwr(st.clk2_lo, reg_wdata_in, WMSK_FULL);
        OFS_CLK2_HI: next_st.clk2_hi = mwr(st.clk2_hi, reg_wdata_in, WMSK_FULL);
        OFS_MUX_TRIM: next_st.mux_trim = mwr(st.mux_trim, reg_wdata_in, WMSK_MUX_TRIM);
        OFS_BUF_TRIM: next_st.buf_trim = mwr(st.buf_trim, reg_wdata_in, WMSK_BUF_TRIM);
        OFS_DBL_BIAS: next_st.dbl_bias = mwr(st.dbl_bias, reg_wdata_in, WMSK_DBL_BIAS);
        default:
        begin
          // counter bytes and unmapped addresses ignore writes
          next_st.hit = st.hit;
        end
      endcase
    end
    // read data is held until the next read so the port can shift it out
    if (reg_rd_in)
    begin
      next_st.rdata = rd_mux;
      next_st.hit = rd_map;
    end
    if (sys_rst_in)
    begin
      next_st.mux_tune = RST_MUX_TUNE;
      next_st.adc_ofs = RST_ADC_OFS;
      next_st.sd_rst = RST_SD_RST;
      next_st.cp_test = RST_CP_TEST;
      next_st.clk1_lo = RST_CLK1_LO;
      next_st.clk1_hi = RST_CLK1_HI;
      next_st.clk2_lo = RST_CLK2_LO;
      next_st.clk2_hi = RST_CLK2_HI;
      next_st.mux_trim = RST_MUX_TRIM;
      next_st.buf_trim = RST_BUF_TRIM;
      next_st.dbl_bias = RST_DBL_BIAS;
      next_st.cnt = 16'h0000;
      next_st.rdata = 8'h00;
      next_st.hit = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    st <= next_st;
  end

  // field outputs straight from the stored registers; the observe output comes from the select mux
  assign reg_rdata_out = st.rdata;
  assign reg_hit_out = st.hit;
  assign calibration_observe_out = obs_raw;
  assign calibration_observe_select_out = st.mux_tune[OBS_SEL_LSB +: 3];
  assign tuning_voltage_target_out = st.mux_tune[TUNE_LSB +: 4];
  assign converter_offset_out = st.adc_ofs;
  assign sigma_delta_reset_out = st.sd_rst[6];
  assign charge_pump_test_mode_out = st.cp_test[CP_MODE_LSB +: 2];
  // any code other than normal is treated as a test mode, 00 tristates the pump
  assign charge_pump_tristate_out = (st.cp_test[CP_MODE_LSB +: 2] == CP_TRISTATE);
  assign first_clock_divider_out = {st.clk1_hi[3:0], st.clk1_lo};
  assign buffer_bias_trim_out = st.clk1_hi[6:4];
  assign second_clock_divider_1_out = {st.clk2_hi[3:0], st.clk2_lo};
  assign second_clock_divider_2_out = st.clk2_hi[7:4];
  assign oscillator_mux_trim_out = st.mux_trim[7:5];
  assign oscillator_buffer_trim_out = st.buf_trim[BUF_TRIM_LSB +: 3];
  assign buffer_current_trim_out = st.buf_trim[4:2];
  assign doubler_filter_select_out = st.dbl_bias[7:5];
  assign doubler_bias_select_out = st.dbl_bias[1:0];

  // checks
  sequence s_wr_cnt;
    reg_wr_in && (reg_addr_in == OFS_CNT_LO || reg_addr_in == OFS_CNT_HI) && !counter_valid_in;
  endsequence

  chk_adc_rst: assert property (@(posedge clk_in) sys_rst_in |=> converter_offset_out == 8'h55)
    else $error("offset reset wrong");
  chk_cp_rst: assert property (@(posedge clk_in) sys_rst_in |=> charge_pump_test_mode_out == 2'h3)
    else $error("charge pump mode reset wrong");
  chk_tune_rst: assert property (@(posedge clk_in) sys_rst_in |=> tuning_voltage_target_out == 4'h7)
    else $error("tuning target reset wrong");
  chk_trim_rst: assert property (@(posedge clk_in) sys_rst_in |=> oscillator_buffer_trim_out == 3'h7)
    else $error("buffer trim reset wrong");
  chk_cnt_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_wr_cnt |=> $stable(st.cnt))
    else $error("counter changed by write");
  chk_cnt_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == OFS_CNT_HI |=> reg_rdata_out == $past(st.cnt[15:8]))
    else $error("counter high byte wrong");
  chk_cp_tri: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == OFS_CP_TEST && reg_wdata_in[3:2] == 2'h0
    |=> charge_pump_tristate_out)
    else $error("charge pump not tristated");
  chk_obs_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    calibration_observe_select_out == 3'h7 |-> !calibration_observe_out)
    else $error("observe not low");
  chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == OFS_MUX_TUNE |=> !reg_rdata_out[7])
    else $error("reserved bit nonzero");
endmodule // svt_regbank

// ===== testbench/svt_regbank_tb.sv
`timescale 1ns/1ps
module svt_regbank_tb;
  import svt_pkg::*;
  // stimulus, driven at the falling edge
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] cand = 6'h00;
  logic [15:0] cnt_val = 16'h0000;
  logic cnt_vld = 1'b0;
  // observed outputs
  logic [7:0] rdata;
  logic hit;
  logic obs;
  logic tri_st;
  logic [2:0] obs_sel;
  logic [2:0] buf_trim;
  logic [3:0] tune;
  logic [7:0] offs;
  logic [1:0] cp_mode;
  logic sd_rst;
  logic [11:0] clk1_div;
  logic [2:0] bias_trim;
  logic [11:0] clk2_div1;
  logic [3:0] clk2_div2;
  logic [2:0] mux_trim;
  logic [2:0] cur_trim;
  logic [2:0] dbl_filt;
  logic [1:0] dbl_bias;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // offset, reset value, writable mask of every mapped register
  logic [23:0] tbl [13] = '{24'h39077f, 24'h3a55ff, 24'h3d0040, 24'h3e0c0c, 24'h3f80ff,
    24'h40507f, 24'h4128ff, 24'h4200ff, 24'h47c0e0, 24'h52f4fc, 24'h6e0000, 24'h6f0000,
    24'h7003e3};

  svt_regbank uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_hit_out(hit), .cal_busy_in(cand[0]), .cal_nband_in(cand[1]),
    .cal_rband_in(cand[2]), .cal_bias_min_in(cand[4]), .cal_adc_busy_in(cand[5]),
    .cal_tclk_in(cand[3]), .oscillator_counter_value_in(cnt_val),
    .counter_valid_in(cnt_vld), .calibration_observe_out(obs),
    .calibration_observe_select_out(obs_sel), .tuning_voltage_target_out(tune),
    .converter_offset_out(offs), .sigma_delta_reset_out(sd_rst),
    .charge_pump_test_mode_out(cp_mode), .charge_pump_tristate_out(tri_st),
    .first_clock_divider_out(clk1_div), .buffer_bias_trim_out(bias_trim),
    .second_clock_divider_1_out(clk2_div1), .second_clock_divider_2_out(clk2_div2),
    .oscillator_mux_trim_out(mux_trim), .oscillator_buffer_trim_out(buf_trim),
    .buffer_current_trim_out(cur_trim), .doubler_filter_select_out(dbl_filt),
    .doubler_bias_select_out(dbl_bias));

  // free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle strobes; the falling edge after the strobe sees the settled answer
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [6:0] a, output logic [7:0] d, output logic h);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    d = rdata;
    h = hit;
  endtask

  task automatic do_reset();
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask

  task automatic check_defaults();
    logic [7:0] d;
    logic h;
    chk("read data after reset", 8'h00, rdata);
    chk("tuning target", 4'h7, tune);
    chk("converter offset", 8'h55, offs);
    chk("pump mode", 2'h3, cp_mode);
    chk("pump tristate", 1'b0, tri_st);
    chk("buffer trim", 3'h7, buf_trim);
    chk("observe select", 3'h0, obs_sel);
    foreach (tbl[i])
    begin
      reg_rd(tbl[i][22:16], d, h);
      chk($sformatf("reset of %h", tbl[i][22:16]), tbl[i][15:8], d);
    end
  endtask

  // every bit set then cleared; reserved and read-only bits must stay zero
  task automatic test_access();
    logic [7:0] d;
    logic h;
    foreach (tbl[i])
    begin
      reg_wr(tbl[i][22:16], 8'hff);
      reg_rd(tbl[i][22:16], d, h);
      chk($sformatf("ones in %h", tbl[i][22:16]), tbl[i][7:0], d);
      chk("hit flag", 1'b1, h);
      reg_wr(tbl[i][22:16], 8'h00);
      reg_rd(tbl[i][22:16], d, h);
      chk($sformatf("zeros in %h", tbl[i][22:16]), 8'h00, d);
    end
    reg_wr(7'h50, 8'hff);
    reg_rd(7'h50, d, h);
    chk("unmapped data", 8'h00, d);
    chk("unmapped hit", 1'b0, h);
  endtask

  task automatic test_fields();
    reg_wr(7'h39, 8'hda);
    chk("tuning target", 4'ha, tune);
    chk("observe select", 3'h5, obs_sel);
    reg_wr(7'h3a, 8'hc3);
    chk("converter offset", 8'hc3, offs);
    reg_wr(7'h3e, 8'hf3);
    chk("pump mode off", 2'h0, cp_mode);
    chk("pump tristate on", 1'b1, tri_st);
    reg_wr(7'h3e, 8'h0c);
    chk("pump mode normal", 2'h3, cp_mode);
    chk("pump tristate off", 1'b0, tri_st);
    reg_wr(7'h52, 8'hb4);
    chk("buffer trim", 3'h5, buf_trim);
    chk("buffer current trim", 3'h5, cur_trim);
    // the remaining field outputs, each from its own bits of the stored bytes
    reg_wr(7'h3d, 8'hff);
    chk("sigma delta reset", 1'b1, sd_rst);
    reg_wr(7'h3f, 8'ha5);
    reg_wr(7'h40, 8'hff);
    chk("first divider", 12'hfa5, clk1_div);
    chk("buffer bias trim", 3'h7, bias_trim);
    reg_wr(7'h41, 8'h3c);
    reg_wr(7'h42, 8'h9b);
    chk("second divider one", 12'hb3c, clk2_div1);
    chk("second divider two", 4'h9, clk2_div2);
    reg_wr(7'h47, 8'hff);
    chk("mux trim", 3'h7, mux_trim);
    reg_wr(7'h70, 8'hff);
    chk("doubler filter", 3'h7, dbl_filt);
    chk("doubler bias", 2'h3, dbl_bias);
  endtask

  // codes 3 and 7 must give low even with every candidate high
  task automatic test_observe();
    int map [8] = '{0, 1, 2, 6, 3, 4, 5, 6};
    logic [5:0] one;
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(7'h39, {1'b0, c[2:0], 4'h7});
      one = (map[c] == 6) ? 6'h00 : 6'h01 << map[c];
      @(negedge clk_in);
      cand = (map[c] == 6) ? 6'h3f : one;
      // the timeout clock passes a three-stage synchroniser, so allow it to settle
      repeat (5) @(negedge clk_in);
      chk($sformatf("observe high, code %0d", c), map[c] != 6, obs);
      cand = ~one;
      repeat (5) @(negedge clk_in);
      chk($sformatf("observe low, code %0d", c), 1'b0, obs);
    end
  endtask

  task automatic test_counter();
    logic [7:0] d;
    logic h;
    @(negedge clk_in);
    cnt_val = 16'h1234;
    cnt_vld = 1'b1;
    @(negedge clk_in);
    cnt_vld = 1'b0;
    cnt_val = 16'hbeef;
    reg_wr(7'h6e, 8'hff);
    reg_wr(7'h6f, 8'h00);
    reg_rd(7'h6e, d, h);
    chk("counter low", 8'h34, d);
    reg_rd(7'h6f, d, h);
    chk("counter high", 8'h12, d);
  endtask

  // main sequence; the second reset lands in mid-run with registers changed
  initial
  begin
    do_reset();
    check_defaults();
    test_fields();
    test_observe();
    test_access();
    test_counter();
    do_reset();
    check_defaults();
    complete_run();
  end
endmodule // svt_regbank_tb
